// File: core/ssl_blink_prescaler.sv
`timescale 1ns/1ps
// ----------------------------------------
// Blink phase generator
// ----------------------------------------
module ssl_blink_prescaler #(
	parameter int HALF_CYCLES = ssl_pkg::BLINK_HALF_CYCLES
) (
	input wire logic clock,
	input wire logic reset,
	output logic phase
);
	localparam int CW = $clog2(HALF_CYCLES);
	logic [CW-1:0] count;
	wire atEnd = (count == CW'(HALF_CYCLES - 1));

	// Phase flips each half period, equal halves
	always_ff @(posedge clock) begin
		if (reset) begin
			count <= '0;
			phase <= 1'b0;
		end else if (atEnd) begin
			count <= '0;
			phase <= ~phase;
		end else begin
			count <= count + 1'b1;
		end
	end
endmodule

// File: core/ssl_pkg.sv
// Function
// - Steady green when booted, ready and no fault of any class is active.
// - Blink green about 1 Hz on any non-critical temperature, voltage or fan threshold.
// - Fan or supply redundancy loss on a redundant system and supply predictive failure also blink green.
// - Over ten correctable errors with sparing blinks green and lights the module indicator.
// - Blink amber on processor error, critical threshold, regulator alarm or interrupt timeout.
// - Steady amber on trip, non-recoverable threshold, power fault or, on a redundant system, lost cooling.
// - Indicator dark when mains off and no condition of any class exists.
// - Upper non-critical threshold ignored unless enabled, then acts like other non-critical.
// - Newest identification request replaces earlier ones; in one cycle off beats on, on beats blink, blink beats button.
// - Button press turns a blinking identification indicator steady, a second press off.
package ssl_pkg;
	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLOCK_HZ = 200000000;
	localparam int BLINK_PERIOD_MS = 1000;
	localparam int BLINK_HALF_CYCLES = CLOCK_HZ / 1000 * BLINK_PERIOD_MS / 2;
	localparam int SPARE_ERROR_LIMIT = 10;
	localparam int ERROR_COUNT_WIDTH = 8;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef enum logic [2:0] {
		SSL_OFF = 3'h0,
		SSL_GREEN = 3'h1,
		SSL_GREEN_BLINK = 3'h2,
		SSL_AMBER_BLINK = 3'h3,
		SSL_AMBER = 3'h4
	} ssl_status_type;

	typedef enum logic [1:0] {
		SSL_ID_OFF = 2'h0,
		SSL_ID_BLINK = 2'h1,
		SSL_ID_ON = 2'h2
	} ssl_id_type;

	// Degraded-class conditions
	typedef struct packed {
		logic tempNonCritical;
		logic voltNonCritical;
		logic fanNonCritical;
		logic upperNonCritical;
		logic fanRedundancyLost;
		logic supplyPredictiveFail;
		logic supplyRedundancyLost;
		logic hostFault;
	} ssl_degraded_type;

	// Critical (blink amber) conditions
	typedef struct packed {
		logic processor_catastrophic_error;
		logic tempCritical;
		logic voltCritical;
		logic fanCritical;
		logic regulator_overheat_alarm;
		logic smiTimeout;
	} ssl_alarm_type;

	// Fatal (steady amber) conditions
	typedef struct packed {
		logic thermalTrip;
		logic tempNonRecoverable;
		logic voltNonRecoverable;
		logic powerFault;
		logic coolingInsufficient;
	} ssl_fatal_type;
endpackage

// File: core/ssl_status_led.sv
`timescale 1ns/1ps
// ----------------------------------------
// System status and identification indicator controller
// ----------------------------------------
module ssl_status_led #(
	parameter int HALF_CYCLES = ssl_pkg::BLINK_HALF_CYCLES,
	parameter int MODULES = 4
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic mainsOn,
	input wire logic bootDone,
	input wire logic redundantSystem,
	input wire logic upperNonCriticalEnable,
	input wire ssl_pkg::ssl_degraded_type degraded,
	input wire ssl_pkg::ssl_alarm_type alarm,
	input wire ssl_pkg::ssl_fatal_type fatal,
	input wire logic correctableError,
	input wire logic [MODULES-1:0] correctableModule,
	input wire logic sparingActive,
	input wire logic idBlinkRequest,
	input wire logic idOnRequest,
	input wire logic idOffRequest,
	input wire logic idButton,
	output logic statusGreen,
	output logic statusAmber,
	output logic idLed,
	output logic [MODULES-1:0] moduleLed,
	output ssl_pkg::ssl_status_type statusState
);
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Control levels, degraded pins without host fault, alarm and fatal pins, button
	localparam int SYNC_W = 4 + ($bits(ssl_pkg::ssl_degraded_type) - 1) + $bits(ssl_pkg::ssl_alarm_type) +
		$bits(ssl_pkg::ssl_fatal_type) + 1;
	logic [SYNC_W-1:0] syncA;
	logic [SYNC_W-1:0] syncB;
	wire [SYNC_W-1:0] rawIn = {mainsOn, bootDone, redundantSystem, upperNonCriticalEnable,
		degraded[7:1], alarm, fatal, idButton};

	// Two stages on the rawIn pins before any logic looks at them
	always_ff @(posedge clock) begin
		if (reset) begin
			syncA <= '0;
			syncB <= '0;
		end else begin
			syncA <= rawIn;
			syncB <= syncA;
		end
	end

	// Synchronised levels, regrouped into the shared carriers
	ssl_pkg::ssl_degraded_type sDegraded;
	ssl_pkg::ssl_alarm_type sAlarm;
	ssl_pkg::ssl_fatal_type sFatal;
	wire sMains = syncB[22];
	wire sBoot = syncB[21];
	wire sRedundant = syncB[20];
	wire sUpperEn = syncB[19];
	// Host fault comes from same-clock logic, so it skips the two stages
	assign sDegraded = {syncB[18:12], degraded.hostFault};
	assign sAlarm = syncB[11:6];
	assign sFatal = syncB[5:1];
	wire sButton = syncB[0];

	// ----------------------------------------
	// Memory sparing error counters
	// ----------------------------------------
	logic [ssl_pkg::ERROR_COUNT_WIDTH-1:0] errCount [MODULES];
	logic [MODULES-1:0] spareHit;

	// Limit kept at counter width so both sides of the compare match
	localparam logic [ssl_pkg::ERROR_COUNT_WIDTH-1:0] ERR_LIMIT =
		ssl_pkg::SPARE_ERROR_LIMIT[ssl_pkg::ERROR_COUNT_WIDTH-1:0];

	genvar m;
	generate
		for (m = 0; m < MODULES; m++) begin : g_module
			// Counter saturates so a storm of errors never wraps back under the limit
			wire countUp = correctableError && correctableModule[m] && !(&errCount[m]);
			wire overLimit = errCount[m] > ERR_LIMIT;
			assign spareHit[m] = overLimit && sparingActive;
			// Saturating count; indicator lit once over limit and spared
			always_ff @(posedge clock) begin
				if (reset) begin
					errCount[m] <= '0;
					moduleLed[m] <= 1'b0;
				end else begin
					if (countUp)
						errCount[m] <= errCount[m] + 1'b1;
					moduleLed[m] <= spareHit[m];
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// Severity classification
	// ----------------------------------------
	// Degraded conditions, shown as green blink
	wire degTemp = sDegraded.tempNonCritical;
	wire degVolt = sDegraded.voltNonCritical;
	wire degFan = sDegraded.fanNonCritical;
	wire degUpper = sDegraded.upperNonCritical & sUpperEn;
	// Redundancy losses mean nothing on a system without spare fans or supplies
	wire degRedund = (sDegraded.fanRedundancyLost | sDegraded.supplyRedundancyLost) & sRedundant;
	wire degPredict = sDegraded.supplyPredictiveFail;
	wire degHost = sDegraded.hostFault;
	wire degSpare = |spareHit;
	wire anyDegraded = degTemp | degVolt | degFan | degUpper | degRedund | degPredict | degHost | degSpare;

	// Likely-to-fail alarms, shown as amber blink
	wire almProcessor = sAlarm.processor_catastrophic_error;
	wire almThreshold = sAlarm.tempCritical | sAlarm.voltCritical | sAlarm.fanCritical;
	wire almRegulator = sAlarm.regulator_overheat_alarm;
	wire almTimeout = sAlarm.smiTimeout;
	wire anyAlarm = almProcessor | almThreshold | almRegulator | almTimeout;

	// Failed or shut down, shown as steady amber
	wire fatTrip = sFatal.thermalTrip;
	wire fatThreshold = sFatal.tempNonRecoverable | sFatal.voltNonRecoverable;
	wire fatPower = sFatal.powerFault;
	// Lost cooling counts only where redundancy exists
	wire fatCooling = sFatal.coolingInsufficient & sRedundant;
	wire anyFatal = fatTrip | fatThreshold | fatPower | fatCooling;

	// Most severe class wins; green needs mains and a finished boot
	ssl_pkg::ssl_status_type next_statusState;
	assign next_statusState = anyFatal ? ssl_pkg::SSL_AMBER :
		anyAlarm ? ssl_pkg::SSL_AMBER_BLINK :
		anyDegraded ? ssl_pkg::SSL_GREEN_BLINK :
		(sMains && sBoot) ? ssl_pkg::SSL_GREEN : ssl_pkg::SSL_OFF;

	// ----------------------------------------
	// Blink phase
	// ----------------------------------------
	logic blinkPhase;
	ssl_blink_prescaler #(.HALF_CYCLES(HALF_CYCLES)) u_prescaler (
		.clock(clock),
		.reset(reset),
		.phase(blinkPhase)
	);

	// ----------------------------------------
	// Status drive
	// ----------------------------------------
	logic next_green;
	logic next_amber;
	always_comb begin
		next_green = 1'b0;
		next_amber = 1'b0;
		case (next_statusState)
			ssl_pkg::SSL_GREEN: next_green = 1'b1;
			ssl_pkg::SSL_GREEN_BLINK: next_green = blinkPhase;
			ssl_pkg::SSL_AMBER_BLINK: next_amber = blinkPhase;
			ssl_pkg::SSL_AMBER: next_amber = 1'b1;
			default: ; // Dark
		endcase
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			statusState <= ssl_pkg::SSL_OFF;
			statusGreen <= 1'b0;
			statusAmber <= 1'b0;
		end else begin
			statusState <= next_statusState;
			statusGreen <= next_green;
			statusAmber <= next_amber;
		end
	end

	// ----------------------------------------
	// Identification indicator
	// ----------------------------------------
	logic buttonLast;
	wire buttonPress = sButton & ~buttonLast;
	ssl_pkg::ssl_id_type idState;
	ssl_pkg::ssl_id_type next_idState;

	// Newest request always wins; simultaneous ones favour command order below
	always_comb begin
		next_idState = idState;
		if (buttonPress) begin
			case (idState)
				ssl_pkg::SSL_ID_BLINK: next_idState = ssl_pkg::SSL_ID_ON;
				ssl_pkg::SSL_ID_ON: next_idState = ssl_pkg::SSL_ID_OFF;
				default: next_idState = ssl_pkg::SSL_ID_ON;
			endcase
		end
		if (idBlinkRequest)
			next_idState = ssl_pkg::SSL_ID_BLINK;
		if (idOnRequest)
			next_idState = ssl_pkg::SSL_ID_ON;
		if (idOffRequest)
			next_idState = ssl_pkg::SSL_ID_OFF;
	end

	// Drive follows the state being entered, so a command shows on the next cycle
	wire next_idLed = (next_idState == ssl_pkg::SSL_ID_ON) ||
		(next_idState == ssl_pkg::SSL_ID_BLINK && blinkPhase);

	always_ff @(posedge clock) begin
		if (reset) begin
			buttonLast <= 1'b0;
			idState <= ssl_pkg::SSL_ID_OFF;
			idLed <= 1'b0;
		end else begin
			buttonLast <= sButton;
			idState <= next_idState;
			idLed <= next_idLed;
		end
	end
endmodule

// File: testbench/ssl_panel_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Front panel indicator as a viewer reads it
// ----------------------------------------
module ssl_panel_model #(
	parameter int HALF_CYCLES = 8
) (
	input wire logic clock,
	input wire logic green,
	input wire logic amber,
	output ssl_pkg::ssl_status_type seen
);
	int gAge = 99;
	int aAge = 99;
	logic gLast = 0;
	logic aLast = 0;
	// Cycles since each colour last changed
	always @(posedge clock) begin
		gAge <= (green !== gLast) ? 0 : gAge + 1;
		aAge <= (amber !== aLast) ? 0 : aAge + 1;
		gLast <= green;
		aLast <= amber;
	end
	// A change within two half periods reads as blinking, so steady needs a full period to show
	assign seen = (aAge <= 2 * HALF_CYCLES) ? ssl_pkg::SSL_AMBER_BLINK : amber ? ssl_pkg::SSL_AMBER :
		(gAge <= 2 * HALF_CYCLES) ? ssl_pkg::SSL_GREEN_BLINK : green ? ssl_pkg::SSL_GREEN : ssl_pkg::SSL_OFF;
endmodule

// File: testbench/ssl_status_led_props.sv
`timescale 1ns/1ps
// ----------------------------------------
// Status and identification indicator checks
// ----------------------------------------
module ssl_status_led_props #(
	parameter int HALF_CYCLES = 8
) (
	input wire logic clock,
	input wire logic reset,
	input wire ssl_pkg::ssl_alarm_type alarm,
	input wire ssl_pkg::ssl_fatal_type fatal,
	input wire logic idOnRequest,
	input wire logic idOffRequest,
	input wire logic statusGreen,
	input wire logic statusAmber,
	input wire logic idLed,
	input wire ssl_pkg::ssl_status_type statusState
);
	logic lit;
	logic prevLit;
	ssl_pkg::ssl_status_type prevState;
	int run;
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// Cycles the lit level has held within one state
	assign lit = statusGreen | statusAmber;
	always_ff @(posedge clock) begin
		prevLit <= lit;
		prevState <= statusState;
		run <= (reset || lit != prevLit || statusState != prevState) ? 1 : run + 1;
	end
	// Conditions held long enough to pass the synchronisers
	sequence fatalHeld;
		(fatal[4:1] != 4'h0)[*5];
	endsequence
	sequence alarmHeld;
		(alarm != 6'h00 && fatal == 5'h00)[*5];
	endsequence
	AST_RESET_DARK: assert property (disable iff (1'b0) reset |=> !lit && !idLed)
		else $error("indicator lit after reset");
	AST_GREEN_SOLID: assert property (statusState == ssl_pkg::SSL_GREEN |-> statusGreen && !statusAmber)
		else $error("green state not steady green");
	AST_AMBER_SOLID: assert property (statusState == ssl_pkg::SSL_AMBER |-> statusAmber && !statusGreen)
		else $error("amber state not steady amber");
	AST_OFF_DARK: assert property (statusState == ssl_pkg::SSL_OFF |-> !lit)
		else $error("off state lit");
	AST_FATAL_WINS: assert property (fatalHeld |-> statusState == ssl_pkg::SSL_AMBER)
		else $error("fatal condition not shown");
	AST_ALARM_BLINK: assert property (alarmHeld |-> statusState == ssl_pkg::SSL_AMBER_BLINK && !statusGreen)
		else $error("alarm condition not shown");
	AST_BLINK_SPAN: assert property (statusState inside {ssl_pkg::SSL_GREEN_BLINK, ssl_pkg::SSL_AMBER_BLINK}
		&& statusState == prevState |-> run <= HALF_CYCLES) else $error("blink half too long");
	AST_ID_OFF: assert property (idOffRequest |=> !idLed)
		else $error("identification not off");
	AST_ID_ON: assert property (idOnRequest && !idOffRequest |=> idLed)
		else $error("identification not on");
endmodule
bind ssl_status_led ssl_status_led_props #(.HALF_CYCLES(HALF_CYCLES)) chk (.clock(clock), .reset(reset),
	.alarm(alarm), .fatal(fatal), .idOnRequest(idOnRequest), .idOffRequest(idOffRequest),
	.statusGreen(statusGreen), .statusAmber(statusAmber), .idLed(idLed), .statusState(statusState));

// File: testbench/ssl_status_led_tb.sv
`timescale 1ns/1ps
module ssl_status_led_tb;
	// ----------------------------------------
	// Stimulus, expectations and verdict
	// ----------------------------------------
	localparam int HALF = 8;
	typedef struct {
		logic [3:0] ctl;
		logic [7:0] deg;
		logic [5:0] alm;
		logic [4:0] fat;
		ssl_pkg::ssl_status_type exp;
	} ssl_row_type;
	logic clock = 0;
	logic reset = 1;
	logic mainsOn = 0, bootDone = 0, redundantSystem = 0, upperNonCriticalEnable = 0, sparingActive = 0;
	logic correctableError = 0, idBlinkRequest = 0, idOnRequest = 0, idOffRequest = 0, idButton = 0;
	logic statusGreen, statusAmber, idLed;
	logic [3:0] correctableModule = 4'h2;
	logic [3:0] moduleLed;
	logic [7:0] v;
	ssl_pkg::ssl_degraded_type degraded = 8'h00;
	ssl_pkg::ssl_alarm_type alarm = 6'h00;
	ssl_pkg::ssl_fatal_type fatal = 5'h00;
	ssl_pkg::ssl_status_type statusState, seen;
	int n_errors = 0;
	int checks = 0;
	// Control nibble: mains, booted, redundant, upper limit enable
	ssl_row_type rows [19] = '{
		'{4'hC, 8'h00, 6'h00, 5'h00, ssl_pkg::SSL_GREEN},
		'{4'h0, 8'h00, 6'h00, 5'h00, ssl_pkg::SSL_OFF},
		'{4'hC, 8'h80, 6'h00, 5'h00, ssl_pkg::SSL_GREEN_BLINK},
		'{4'hC, 8'h20, 6'h00, 5'h00, ssl_pkg::SSL_GREEN_BLINK},
		'{4'hC, 8'h10, 6'h00, 5'h00, ssl_pkg::SSL_GREEN},
		'{4'hD, 8'h10, 6'h00, 5'h00, ssl_pkg::SSL_GREEN_BLINK},
		'{4'hC, 8'h08, 6'h00, 5'h00, ssl_pkg::SSL_GREEN},
		'{4'hE, 8'h02, 6'h00, 5'h00, ssl_pkg::SSL_GREEN_BLINK},
		'{4'hC, 8'h01, 6'h00, 5'h00, ssl_pkg::SSL_GREEN_BLINK},
		'{4'hC, 8'h00, 6'h20, 5'h00, ssl_pkg::SSL_AMBER_BLINK},
		'{4'hC, 8'h00, 6'h01, 5'h00, ssl_pkg::SSL_AMBER_BLINK},
		'{4'hC, 8'h00, 6'h00, 5'h10, ssl_pkg::SSL_AMBER},
		'{4'hE, 8'h00, 6'h00, 5'h01, ssl_pkg::SSL_AMBER},
		'{4'hC, 8'h04, 6'h00, 5'h00, ssl_pkg::SSL_GREEN_BLINK},
		'{4'hC, 8'h40, 6'h00, 5'h00, ssl_pkg::SSL_GREEN_BLINK},
		'{4'hC, 8'h00, 6'h00, 5'h01, ssl_pkg::SSL_GREEN},
		'{4'hC, 8'h00, 6'h00, 5'h02, ssl_pkg::SSL_AMBER},
		'{4'hC, 8'hFF, 6'h3F, 5'h1F, ssl_pkg::SSL_AMBER},
		'{4'h0, 8'h80, 6'h01, 5'h00, ssl_pkg::SSL_AMBER_BLINK}
	};
	always #2.5 clock = ~clock;
	ssl_status_led #(.HALF_CYCLES(HALF)) uut (.clock, .reset, .mainsOn, .bootDone, .redundantSystem,
		.upperNonCriticalEnable, .degraded, .alarm, .fatal, .correctableError, .correctableModule, .sparingActive,
		.idBlinkRequest, .idOnRequest, .idOffRequest, .idButton, .statusGreen, .statusAmber, .idLed, .moduleLed,
		.statusState);
	ssl_panel_model #(.HALF_CYCLES(HALF)) panel (.clock, .green(statusGreen), .amber(statusAmber), .seen);
	// Inputs move 1 ns after the edge so the design never races the bench
	task step(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1;
		step(1);
		s = 0;
		step(1);
	endtask
	task chk_state(input string name, input ssl_pkg::ssl_status_type exp, got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %0d seen %0d", name, exp, got);
		end
	endtask
	task chk_bits(input string name, input logic [7:0] exp, got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Bit 1 marks lit and bit 0 dark over two blink periods
	task sweep;
		v = 8'h00;
		repeat (4 * HALF) begin
			step(1);
			v = v | (idLed ? 8'h02 : 8'h01);
		end
	endtask
	task press;
		idButton = 1;
		step(6);
		idButton = 0;
		step(6);
		sweep;
	endtask
	task give_verdict;
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		step(5);
		reset = 0;
		step(1);
		chk_state("reset state", ssl_pkg::SSL_OFF, statusState);
		foreach (rows[i]) begin
			{mainsOn, bootDone, redundantSystem, upperNonCriticalEnable} = rows[i].ctl;
			degraded = rows[i].deg;
			alarm = rows[i].alm;
			fatal = rows[i].fat;
			step(4 * HALF);
			chk_state("statusState", rows[i].exp, statusState);
			chk_state("panel", rows[i].exp, seen);
		end
		$display("condition rows done");
		{mainsOn, bootDone, degraded, alarm, fatal} = 21'h180000;
		sparingActive = 1;
		repeat (10) pulse(correctableError);
		step(4 * HALF);
		chk_bits("moduleLed at ten", 8'h00, {4'h0, moduleLed});
		pulse(correctableError);
		step(4 * HALF);
		chk_bits("moduleLed past ten", 8'h02, {4'h0, moduleLed});
		chk_state("sparing state", ssl_pkg::SSL_GREEN_BLINK, statusState);
		$display("sparing done");
		pulse(idBlinkRequest);
		sweep;
		chk_bits("id blink", 8'h03, v);
		press;
		chk_bits("id steady", 8'h02, v);
		press;
		chk_bits("id off", 8'h01, v);
		pulse(idOnRequest);
		chk_bits("id on", 8'h01, {7'h00, idLed});
		{idBlinkRequest, idOffRequest} = 2'h3;
		step(1);
		{idBlinkRequest, idOffRequest} = 2'h0;
		sweep;
		chk_bits("id off wins", 8'h01, v);
		$display("identification done");
		fatal = 5'h10;
		reset = 1;
		step(2);
		chk_state("mid reset", ssl_pkg::SSL_OFF, statusState);
		chk_bits("moduleLed in reset", 8'h00, {4'h0, moduleLed});
		reset = 0;
		step(4 * HALF);
		chk_state("after reset", ssl_pkg::SSL_AMBER, statusState);
		$display("reset done");
		give_verdict;
	end
	// Watchdog well beyond the expected run
	initial begin
		#60000;
		n_errors++;
		give_verdict;
	end
endmodule
